// ===== src/pdc_pkg.sv
`default_nettype none
package pdc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam int CTRL_EQ_DIS_BIT = 0;
	localparam int CTRL_COLL_TEST_BIT = 1;
	localparam int CTRL_FULL_DPX_BIT = 2;
	localparam int CTRL_SPEED100_BIT = 3;
	localparam int CTRL_LOOPBACK_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h08;
	localparam int STAT_LINK_BIT = 0;
	localparam int STAT_COL_BIT = 1;
	localparam int STAT_CRS_BIT = 2;
	localparam int STAT_BAD_SSD_BIT = 3;
	localparam int STAT_BAD_ESD_BIT = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Code groups
	// ----------------------------------------
	localparam logic [4:0] SYM_I = 5'h1f;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0d;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [3:0] NIB_FIVE = 4'h5;
	localparam logic [3:0] NIB_FALSE_CARRIER = 4'he;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int SOI_NS = 250;
	localparam int SOI_CYCLES = (SOI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
	} pdc_rx_type;

	typedef struct packed {
		logic crs;
		logic dv;
		logic er;
		logic [3:0] d;
	} pdc_mii_rx_type;

	typedef struct packed {
		logic drive;
		logic soi;
		logic [4:0] code;
	} pdc_tx_line_type;

	// ----------------------------------------
	// 4B5B tables
	// ----------------------------------------
	function automatic logic [4:0] pdc_encode(input logic [3:0] nib);
		logic [79:0] table_v;
		table_v = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
			5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
		return table_v[nib * 5 +: 5];
	endfunction

	function automatic logic [4:0] pdc_decode(input logic [4:0] code);
		logic [4:0] result;
		result = 5'h10;
		for (int n = 0; n < 16; n++) begin
			if (pdc_encode(4'(n)) == code) begin
				result = {1'b0, 4'(n)};
			end
		end
		return result;
	endfunction

endpackage
`default_nettype wire

// ===== src/pdc_rx_decoder.sv
`default_nettype none
module pdc_rx_decoder (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic [4:0] rx_code,
	output pdc_pkg::pdc_rx_type rx,
	output logic active,
	output logic nonidle,
	output logic bad_ssd,
	output logic bad_esd
);
	typedef enum logic [1:0] {ST_IDLE, ST_FALSE, ST_RECV} pdc_dec_state_type;

	// ----------------------------------------
	// Window of two code groups
	// ----------------------------------------
	logic [4:0] prev_code;
	logic first_k;
	pdc_dec_state_type state;
	pdc_dec_state_type next_state;
	wire logic [9:0] window = {prev_code, rx_code};
	wire logic is_ii = window == {pdc_pkg::SYM_I, pdc_pkg::SYM_I};
	wire logic is_jk = window == {pdc_pkg::SYM_J, pdc_pkg::SYM_K};
	wire logic is_tr = window == {pdc_pkg::SYM_T, pdc_pkg::SYM_R};
	wire logic is_ij = window == {pdc_pkg::SYM_I, pdc_pkg::SYM_J};
	wire logic [4:0] prev_dec = pdc_pkg::pdc_decode(prev_code);

	// Two zeros with at least one bit between them
	function automatic logic split_zeros(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int a = 0; a < 10; a++) begin
			for (int b = a + 2; b < 10; b++) begin
				if (!w[a] && !w[b]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	// Idle then J is the leading half of a start, not a false carrier
	wire logic false_start = !is_ii && !is_jk && !is_ij && split_zeros(window);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (is_jk) begin
					next_state = ST_RECV;
				end else if (false_start) begin
					next_state = ST_FALSE;
				end
			end
			ST_FALSE: begin
				if (is_ii) begin
					next_state = ST_IDLE;
				end
			end
			ST_RECV: begin
				if (is_tr || is_ii) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (!enable) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			prev_code <= pdc_pkg::SYM_I;
			first_k <= 1'b0;
			rx <= '0;
			active <= 1'b0;
			nonidle <= 1'b0;
			bad_ssd <= 1'b0;
			bad_esd <= 1'b0;
		end else begin
			state <= next_state;
			prev_code <= rx_code;
			nonidle <= enable && rx_code != pdc_pkg::SYM_I;
			active <= next_state == ST_RECV;
			bad_ssd <= enable && state == ST_IDLE && !is_jk && false_start;
			bad_esd <= enable && state == ST_RECV && !is_tr && is_ii;
			first_k <= state == ST_IDLE && is_jk;
			rx <= '0;
			if (enable) begin
				case (state)
					ST_IDLE: begin
						if (is_jk) begin
							rx <= '{dv: 1'b1, er: 1'b0, d: pdc_pkg::NIB_FIVE};
						end else if (false_start) begin
							rx <= '{dv: 1'b0, er: 1'b1, d: pdc_pkg::NIB_FALSE_CARRIER};
						end
					end
					ST_RECV: begin
						if (first_k) begin
							rx <= '{dv: 1'b1, er: 1'b0, d: pdc_pkg::NIB_FIVE};
						end else if (is_tr) begin
							rx <= '0;
						end else if (is_ii) begin
							rx <= '{dv: 1'b1, er: 1'b1, d: 4'h0};
						end else begin
							rx <= '{dv: 1'b1, er: prev_dec[4], d: prev_dec[3:0]};
						end
					end
					default: rx <= '0;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ===== src/pdc_top.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module pdc_top #(
	parameter int EQ_WIDTH = 4,
	parameter logic [EQ_WIDTH-1:0] EQ_ZERO_LEN = '0,
	parameter int SOI_LEN = pdc_pkg::SOI_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_en,
	input wire logic [3:0] txd,
	output pdc_pkg::pdc_mii_rx_type mii_rx,
	output logic col,
	output pdc_pkg::pdc_tx_line_type twisted_pair_tx_out,
	input wire logic [4:0] rx_code,
	input wire logic descr_locked,
	input wire logic [3:0] rx10_nibble,
	input wire logic squelch10_pin,
	input wire logic soi10_pin,
	input wire logic nlp_link_ok_pin,
	input wire logic squelch100_pin,
	input wire logic sqe_test_pin,
	input wire logic jabber_pin,
	input wire logic [EQ_WIDTH-1:0] eq_adapt,
	output logic [EQ_WIDTH-1:0] eq_setting,
	output logic link_pass
);
	typedef enum logic [2:0] {TX_IDLE, TX_J, TX_K, TX_DATA, TX_T, TX_R} pdc_tx_state_type;
	pdc_tx_state_type tx_state;
	pdc_tx_state_type next_tx_state;
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	wire logic squelch10 = pin_sync[0];
	wire logic soi10 = pin_sync[1];
	wire logic nlp_ok = pin_sync[2];
	wire logic squelch100 = pin_sync[3];
	wire logic sqe_test = pin_sync[4];
	wire logic jabber = pin_sync[5];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {jabber_pin, sqe_test_pin, squelch100_pin, nlp_link_ok_pin,
				soi10_pin, squelch10_pin};
			pin_sync <= pin_meta;
		end
	end
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [4:0] ctrl;
	logic bad_ssd_flag;
	logic bad_esd_flag;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take = s_axi_wvalid && s_axi_wready;
	wire logic do_write = aw_held && w_held && !s_axi_bvalid;
	wire logic wr_ctrl = do_write && aw_addr == pdc_pkg::CTRL_ADDR && w_strb[0];
	wire logic wr_stat = do_write && aw_addr == pdc_pkg::STATUS_ADDR && w_strb[0];
	wire logic wr_known = aw_addr == pdc_pkg::CTRL_ADDR || aw_addr == pdc_pkg::STATUS_ADDR;
	wire logic clr_ssd = wr_stat && w_data[pdc_pkg::STAT_BAD_SSD_BIT];
	wire logic clr_esd = wr_stat && w_data[pdc_pkg::STAT_BAD_ESD_BIT];
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic eq_dis = ctrl[pdc_pkg::CTRL_EQ_DIS_BIT];
	wire logic coll_test = ctrl[pdc_pkg::CTRL_COLL_TEST_BIT];
	wire logic full_dpx = ctrl[pdc_pkg::CTRL_FULL_DPX_BIT];
	wire logic speed100 = ctrl[pdc_pkg::CTRL_SPEED100_BIT];
	wire logic loopback = ctrl[pdc_pkg::CTRL_LOOPBACK_BIT];
	logic [31:0] stat_word;
	logic [31:0] read_word;
	logic read_known;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pdc_pkg::RESP_OKAY;
			ctrl <= pdc_pkg::CTRL_RESET;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (wr_ctrl) begin
				ctrl <= w_data[4:0];
			end
		end
	end
	always_comb begin
		stat_word = '0;
		stat_word[pdc_pkg::STAT_LINK_BIT] = link_pass;
		stat_word[pdc_pkg::STAT_COL_BIT] = col;
		stat_word[pdc_pkg::STAT_CRS_BIT] = mii_rx.crs;
		stat_word[pdc_pkg::STAT_BAD_SSD_BIT] = bad_ssd_flag;
		stat_word[pdc_pkg::STAT_BAD_ESD_BIT] = bad_esd_flag;
		read_known = 1'b1;
		case (s_axi_araddr)
			pdc_pkg::CTRL_ADDR: read_word = {27'h0, ctrl};
			pdc_pkg::STATUS_ADDR: read_word = stat_word;
			default: begin
				read_word = '0;
				read_known = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= pdc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= read_known ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// ----------------------------------------
	// 100 Mbps receive decoder
	// ----------------------------------------
	pdc_pkg::pdc_rx_type dec_rx;
	logic dec_active;
	logic dec_nonidle;
	logic dec_bad_ssd;
	logic dec_bad_esd;
	pdc_rx_decoder u_dec (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(speed100),
		.rx_code(rx_code),
		.rx(dec_rx),
		.active(dec_active),
		.nonidle(dec_nonidle),
		.bad_ssd(dec_bad_ssd),
		.bad_esd(dec_bad_esd)
	);
	// Set beats a same-cycle clear so no event is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bad_ssd_flag <= 1'b0;
			bad_esd_flag <= 1'b0;
		end else begin
			bad_ssd_flag <= dec_bad_ssd || (bad_ssd_flag && !clr_ssd);
			bad_esd_flag <= dec_bad_esd || (bad_esd_flag && !clr_esd);
		end
	end
	// ----------------------------------------
	// 10 Mbps receive framing
	// ----------------------------------------
	logic rx10_active;
	wire logic next_rx10_active = speed100 ? 1'b0 :
		soi10 ? 1'b0 : (squelch10 || rx10_active);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx10_active <= 1'b0;
		end else begin
			rx10_active <= next_rx10_active;
		end
	end
	// ----------------------------------------
	// Collision and link
	// ----------------------------------------
	wire logic next_link = speed100 ? (squelch100 && descr_locked) : nlp_ok;
	wire logic tx_busy = tx_en || tx_state != TX_IDLE;
	wire logic receiving = speed100 ? dec_nonidle : squelch10;
	wire logic coll_ok = !full_dpx && link_pass && !loopback;
	wire logic coll_raw = tx_busy && receiving && coll_ok;
	wire logic coll_10 = !speed100 && (sqe_test || jabber);
	wire logic next_col = coll_test ? tx_en : (coll_raw || coll_10);
	pdc_pkg::pdc_mii_rx_type next_mii;
	always_comb begin
		if (speed100) begin
			next_mii = {dec_active || dec_rx.dv, dec_rx};
		end else begin
			next_mii.crs = next_rx10_active;
			next_mii.dv = next_rx10_active;
			next_mii.er = 1'b0;
			next_mii.d = (next_rx10_active && !coll_raw) ? rx10_nibble : 4'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_pass <= 1'b0;
			col <= 1'b0;
			mii_rx <= '0;
			eq_setting <= EQ_ZERO_LEN;
		end else begin
			link_pass <= next_link;
			col <= next_col;
			mii_rx <= next_mii;
			eq_setting <= eq_dis ? EQ_ZERO_LEN : eq_adapt;
		end
	end
	// ----------------------------------------
	// Transmit encoder
	// ----------------------------------------
	logic [15:0] soi_count;
	logic tx_en_d;
	logic [4:0] next_code;
	wire logic soi_start = !speed100 && tx_en_d && !tx_en;
	// Jabber only cuts the driver at 10 Mbps; the test mode never drives
	wire logic drive_block = coll_test || (!speed100 && jabber);
	always_comb begin
		next_tx_state = tx_state;
		next_code = pdc_pkg::SYM_I;
		case (tx_state)
			TX_IDLE: begin
				if (tx_en) begin
					next_tx_state = TX_J;
				end
			end
			TX_J: next_tx_state = TX_K;
			TX_K: next_tx_state = tx_en ? TX_DATA : TX_T;
			TX_DATA: begin
				if (!tx_en) begin
					next_tx_state = TX_T;
				end
			end
			TX_T: next_tx_state = TX_R;
			TX_R: next_tx_state = TX_IDLE;
			default: next_tx_state = TX_IDLE;
		endcase
		if (!speed100) begin
			next_tx_state = TX_IDLE;
		end
		case (next_tx_state)
			TX_J: next_code = pdc_pkg::SYM_J;
			TX_K: next_code = pdc_pkg::SYM_K;
			TX_DATA: next_code = pdc_pkg::pdc_encode(txd);
			TX_T: next_code = pdc_pkg::SYM_T;
			TX_R: next_code = pdc_pkg::SYM_R;
			default: next_code = pdc_pkg::SYM_I;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state <= TX_IDLE;
			tx_en_d <= 1'b0;
			soi_count <= '0;
			twisted_pair_tx_out <= '0;
		end else begin
			tx_state <= next_tx_state;
			tx_en_d <= tx_en;
			if (soi_start) begin
				soi_count <= 16'(SOI_LEN);
			end else if (soi_count != '0) begin
				soi_count <= soi_count - 16'h1;
			end
			if (speed100) begin
				twisted_pair_tx_out.code <= next_code;
				twisted_pair_tx_out.soi <= 1'b0;
				twisted_pair_tx_out.drive <= next_tx_state != TX_IDLE && !drive_block;
			end else begin
				twisted_pair_tx_out.code <= {1'b0, txd};
				twisted_pair_tx_out.soi <= soi_start || soi_count > 16'h1;
				twisted_pair_tx_out.drive <= (tx_en || soi_start || soi_count > 16'h1) &&
					!drive_block;
			end
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	eq_forced_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eq_dis |=> eq_setting == EQ_ZERO_LEN) else $error("equalizer not forced");
	coll_detect_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!coll_test && coll_raw) |=> col) else $error("collision missed");
	coll_inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!coll_test && full_dpx && !coll_10) |=> !col) else $error("collision in full duplex");
	rx10_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!speed100 && coll_raw) |=> mii_rx.d == 4'h0) else $error("10M data not zeroed");
	jabber_col_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!coll_test && !speed100 && jabber) |=> col && !twisted_pair_tx_out.drive)
		else $error("jabber not signalled");
	coll_test_a: assert property (@(posedge aclk) disable iff (!aresetn)
		coll_test |=> col == $past(tx_en) && !twisted_pair_tx_out.drive)
		else $error("collision test loop wrong");
	tx_ssd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(speed100 && $rose(tx_en) && tx_state == TX_IDLE) ##1 speed100 |->
		(twisted_pair_tx_out.code == pdc_pkg::SYM_J) ##1
		(twisted_pair_tx_out.code == pdc_pkg::SYM_K)) else $error("start delimiter wrong");
	tx_esd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(speed100 && tx_state == TX_DATA && !tx_en) ##1 speed100 |->
		(twisted_pair_tx_out.code == pdc_pkg::SYM_T) ##1
		(twisted_pair_tx_out.code == pdc_pkg::SYM_R)) else $error("end delimiter wrong");
	ssd_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		dec_bad_ssd |=> bad_ssd_flag) else $error("bad start flag lost");
	soi_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(soi_start && !drive_block) |=> twisted_pair_tx_out.soi) else $error("no start of idle");
	link_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(speed100 && !descr_locked) |=> !link_pass) else $error("link without lock");
endmodule
`default_nettype wire

// ===== verification/pdc_mac_model.sv
`default_nettype none
module pdc_mac_model (
	input wire logic aclk,
	input wire logic go,
	input wire logic [15:0] frame,
	input wire logic [2:0] len,
	output logic tx_en,
	output logic [3:0] txd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] left;
	logic [15:0] sh;
	initial begin
		tx_en = 1'b0;
		txd = 4'h0;
		left = 3'h0;
		sh = 16'h0;
	end
	// Idle nibble inverted each cycle so stale data never passes as valid
	always @(posedge aclk) begin
		if (go && !tx_en) begin
			tx_en <= 1'b1;
			txd <= frame[15:12];
			sh <= frame << 4;
			left <= len - 3'h1;
		end else if (tx_en && left != 3'h0) begin
			txd <= sh[15:12];
			sh <= sh << 4;
			left <= left - 3'h1;
		end else begin
			tx_en <= 1'b0;
			txd <= ~txd;
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rd, cd;
	logic [1:0] rs;
	logic awready, wready, bvalid, arready, rvalid, col, link_pass, tx_en, mac_go;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] txd, rx10, eq_adapt, eq_setting;
	logic [15:0] frame;
	logic [2:0] len;
	logic [4:0] rx_code;
	logic locked, sq10, soi10, nlp, sq100, sqe, jab;
	pdc_pkg::pdc_mii_rx_type mii_rx;
	pdc_pkg::pdc_tx_line_type tpo;
	int n_errors = 0;
	int tests_run = 0;
	int nd, ns, nc, ner, nfc;
	// Short pulse keeps the run brief; expectations use this value
	pdc_top #(.SOI_LEN(3)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tx_en(tx_en), .txd(txd), .mii_rx(mii_rx), .col(col),
		.twisted_pair_tx_out(tpo), .rx_code(rx_code), .descr_locked(locked),
		.rx10_nibble(rx10), .squelch10_pin(sq10), .soi10_pin(soi10),
		.nlp_link_ok_pin(nlp), .squelch100_pin(sq100), .sqe_test_pin(sqe),
		.jabber_pin(jab), .eq_adapt(eq_adapt), .eq_setting(eq_setting),
		.link_pass(link_pass));
	pdc_mac_model mac (.aclk(aclk), .go(mac_go), .frame(frame), .len(len), .tx_en(tx_en),
		.txd(txd));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		rs = bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rd = rdata;
		rs = rresp;
	endtask
	task automatic tx_run(input logic [15:0] f, input logic [2:0] n);
		mac_go <= 1'b1;
		frame <= f;
		len <= n;
		cd = 32'h0;
		nd = 0;
		ns = 0;
		nc = 0;
		repeat (14) begin
			@(posedge aclk);
			mac_go <= 1'b0;
			if (tpo.drive === 1'b1) cd = {cd[26:0], tpo.code};
			nd += int'(tpo.drive === 1'b1);
			ns += int'(tpo.soi === 1'b1);
			nc += int'(col === 1'b1);
		end
	endtask
	task automatic rx_run(input logic [4:0] s [$]);
		cd = 32'h0;
		ner = 0;
		nfc = 0;
		for (int i = 0; i < s.size() + 4; i++) begin
			rx_code <= (i < s.size()) ? s[i] : pdc_pkg::SYM_I;
			@(posedge aclk);
			if (mii_rx.dv === 1'b1) cd = {cd[27:0], mii_rx.d};
			ner += int'(mii_rx.dv === 1'b1 && mii_rx.er === 1'b1);
			nfc += int'(mii_rx.dv === 1'b0 && mii_rx.er === 1'b1 && mii_rx.d === 4'he);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		axi_rd(pdc_pkg::CTRL_ADDR);
		chk("ctrl reset", 32'h08, rd);
		axi_wr(8'h10, 32'h1f);
		chk("bresp unmapped", 32'(pdc_pkg::RESP_SLVERR), 32'(rs));
		axi_rd(8'h10);
		chk("rresp unmapped", 32'(pdc_pkg::RESP_SLVERR), 32'(rs));
		axi_rd(pdc_pkg::CTRL_ADDR);
		chk("ctrl kept", 32'h08, rd);
		chk("link100", 32'h1, 32'(link_pass));
		eq_adapt <= 4'h7;
		axi_wr(pdc_pkg::CTRL_ADDR, 32'h09);
		repeat (3) @(posedge aclk);
		chk("eq zero", 32'h0, 32'(eq_setting));
		axi_wr(pdc_pkg::CTRL_ADDR, 32'h08);
		repeat (3) @(posedge aclk);
		chk("eq adapt", 32'h7, 32'(eq_setting));
		$display("regs done");
	endtask
	task automatic t_tx100();
		tx_run(16'h555d, 3'h4);
		chk("tx codes", {2'b0, pdc_pkg::SYM_J, pdc_pkg::SYM_K, 5'h0b, 5'h1b,
			pdc_pkg::SYM_T, pdc_pkg::SYM_R}, cd);
		chk("tx groups", 32'h6, 32'(nd));
		$display("tx100 done");
	endtask
	task automatic t_rx100();
		rx_run('{5'h1f, 5'h1e, 5'h1f, 5'h1f});
		chk("ignored", 32'h0, cd | 32'(ner) | 32'(nfc));
		rx_run('{5'h1f, 5'h1f, 5'h18, 5'h11, 5'h0b, 5'h1b, 5'h0d, 5'h07});
		chk("rx nibbles", 32'h555d, cd);
		chk("rx er", 32'h0, 32'(ner));
		rx_run('{5'h1f, 5'h1f, 5'h18, 5'h11, 5'h0b, 5'h1f, 5'h1f});
		chk("early end er", 32'h1, 32'(ner));
		axi_rd(pdc_pkg::STATUS_ADDR);
		chk("bad end", 32'h1, 32'(rd[4]));
		axi_wr(pdc_pkg::STATUS_ADDR, 32'h18);
		rx_run('{5'h1f, 5'h1f, 5'h0a, 5'h18, 5'h11, 5'h0b, 5'h1f, 5'h1f, 5'h18, 5'h11,
			5'h0b, 5'h1b, 5'h0d, 5'h07});
		chk("false carrier", 32'h1, 32'(nfc != 0));
		chk("restart", 32'h555d, cd);
		axi_rd(pdc_pkg::STATUS_ADDR);
		chk("bad start", 32'h1, 32'(rd[4:3] == 2'b01));
		$display("rx100 done");
	endtask
	task automatic coll_case(input logic [31:0] ctl, input logic lk, input int ec,
		input int ed);
		axi_wr(pdc_pkg::CTRL_ADDR, ctl);
		locked <= lk;
		rx_code <= 5'h0b;
		repeat (8) @(posedge aclk);
		tx_run(16'h5555, 3'h4);
		chk("col", 32'(ec), 32'(nc));
		if (ec > 0) chk("col seen", 32'h1, 32'(nc > 0));
		chk("drive", 32'(ed), 32'(nd));
		rx_code <= pdc_pkg::SYM_I;
		locked <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask
	task automatic t_coll();
		coll_case(32'h08, 1'b1, 7, 6);
		coll_case(32'h0c, 1'b1, 0, 6);
		coll_case(32'h18, 1'b1, 0, 6);
		coll_case(32'h08, 1'b0, 0, 6);
		coll_case(32'h0a, 1'b1, 4, 0);
		$display("collision done");
	endtask
	task automatic t_ten();
		axi_wr(pdc_pkg::CTRL_ADDR, 32'h00);
		sq100 <= 1'b0;
		nlp <= 1'b1;
		rx10 <= 4'h9;
		sq10 <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("link10", 32'h1, 32'(link_pass));
		chk("crs10", 32'h3, 32'({mii_rx.crs, mii_rx.dv}));
		chk("d10", 32'h9, 32'(mii_rx.d));
		sqe <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("sqe col", 32'h1, 32'(col));
		sqe <= 1'b0;
		frame <= 16'h0;
		len <= 3'h7;
		mac_go <= 1'b1;
		repeat (4) @(posedge aclk);
		mac_go <= 1'b0;
		chk("tx col10", 32'h1, 32'(col));
		chk("zero data", 32'h0, 32'(mii_rx.d));
		jab <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("jabber col", 32'h1, 32'(col));
		jab <= 1'b0;
		soi10 <= 1'b1;
		nlp <= 1'b0;
		repeat (6) @(posedge aclk);
		chk("soi end", 32'h0, 32'({mii_rx.crs, mii_rx.dv}));
		chk("link lost", 32'h0, 32'(link_pass));
		sq10 <= 1'b0;
		soi10 <= 1'b0;
		tx_run(16'h5500, 3'h2);
		chk("soi pulse", 32'h3, 32'(ns));
		$display("ten done");
	endtask
	// ----------------------------------------
	// Run
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Whole run needs under 2000 cycles
	initial begin
		repeat (6000) @(posedge aclk);
		n_errors++;
		close_out();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, mac_go} = 7'h0;
		{awaddr, araddr, wdata, frame, len, eq_adapt, rx10} = '0;
		{sq10, soi10, nlp, sqe, jab} = 5'h0;
		{locked, sq100} = 2'b11;
		rx_code = pdc_pkg::SYM_I;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_tx100();
		t_rx100();
		t_coll();
		t_ten();
		close_out();
	end
endmodule
`default_nettype wire
